// file: core/rsac_zone_two_guard.v
// Zone-two access guard: storage, security flags and Wishbone command port
// What this block does
// - Address 480 bit gates zone writes
// - Address 481 bit gates zone reads
// - Read allowed if read bit or verified
// - Level one: verified erase clears whole zone
// - Level two erase needs password, counter, fuse
// - Fuse one limits zone to 128 erases
// - Fuse zero: no counting, no limit
// - Count fuse frozen once issuer fuse blown
// - Level one: bit writes outside the test zone need verified code
// - Level two: zone writes also need write bit
// - Password written in level one after verification
// - Password frozen once issuer fuse blown
// - Level two erase needs code and password
// - Password match sets erase-enabled flag
// - Counter active only level two, fuse one
// - Counter bit cleared before each erase
// - Counter exhausted blocks zone erases only in level two with fuse one
// - Counter writable toward zero, never erased
// - Test zone always fully accessible
// - Issuer fuse one means level one
// - Code presentation sets verified flag
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "rsac_zone_two_map.vh"
module rsac_zone_two_guard #(
	parameter ZONE_BITS = 256,
	parameter PW_BITS = 32,
	parameter CNT_BITS = 128,
	parameter TEST_BITS = 16
) (
	input wire clk_i,
	input wire rst_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	input wire issuer_fuse_i,
	input wire code_verify_i,
	output wire code_verified_flag_o,
	output wire zone_two_erase_ok_flag_o,
	output wire level_one_o
);
	// Maps a memory bit address to the region that holds it
	function [2:0] region_of;
		input [10:0] a;
		begin
			if (a >= `RSAC_ADR_ZONE_BASE && a < `RSAC_ADR_PW_BASE)
				region_of = `RSAC_RG_ZONE;
			else if (a >= `RSAC_ADR_PW_BASE && a < `RSAC_ADR_CNT_BASE)
				region_of = `RSAC_RG_PW;
			else if (a >= `RSAC_ADR_CNT_BASE && a < `RSAC_ADR_CNT_BASE + 11'h080)
				region_of = `RSAC_RG_CNT;
			else if (a >= `RSAC_ADR_FUSE_BASE && a <= `RSAC_ADR_FUSE_LAST)
				region_of = `RSAC_RG_FUSE;
			else if (a >= `RSAC_ADR_TEST_BASE && a < `RSAC_ADR_TEST_BASE + 11'h010)
				region_of = `RSAC_RG_TEST;
			else
				region_of = `RSAC_RG_NONE;
		end
	endfunction

	// Offset of an address inside its region
	function [10:0] offset_of;
		input [2:0] rg;
		input [10:0] a;
		begin
			case (rg)
				`RSAC_RG_ZONE: offset_of = a - `RSAC_ADR_ZONE_BASE;
				`RSAC_RG_PW: offset_of = a - `RSAC_ADR_PW_BASE;
				`RSAC_RG_CNT: offset_of = a - `RSAC_ADR_CNT_BASE;
				`RSAC_RG_TEST: offset_of = a - `RSAC_ADR_TEST_BASE;
				default: offset_of = 11'h000;
			endcase
		end
	endfunction

	// Smallest index width that reaches every bit of a field
	function integer idx_width;
		input integer n;
		integer w;
		begin
			w = 1;
			while ((1 << w) < n)
			begin
				w = w + 1;
			end
			idx_width = w;
		end
	endfunction

	localparam ZONE_IW = idx_width(ZONE_BITS);
	localparam PW_IW = idx_width(PW_BITS);
	localparam CNT_IW = idx_width(CNT_BITS);
	localparam TEST_IW = idx_width(TEST_BITS);

	reg ack_q;
	reg [31:0] dat_q;
	reg [31:0] pwcmp_q;
	reg verified_q;
	reg erase_ok_q;
	reg fuse_q;
	reg tick_q;
	reg rdbit_q;
	reg refused_q;

	wire [ZONE_BITS-1:0] zone_bits;
	wire [PW_BITS-1:0] pw_bits;
	wire [CNT_BITS-1:0] cnt_bits;
	wire [TEST_BITS-1:0] test_bits;

	wire req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wr_req = req & wb_we_i;
	wire rd_req = req & ~wb_we_i;
	wire cmd_go = wr_req & (wb_adr_i == `RSAC_REG_CMD) & (wb_sel_i == 4'hF);
	wire [1:0] op = wb_dat_i[`RSAC_CMD_OP_MSB:`RSAC_CMD_OP_LSB];
	wire [10:0] madr = wb_dat_i[`RSAC_CMD_ADR_MSB:`RSAC_CMD_ADR_LSB];
	wire [2:0] region = region_of(madr);
	wire [10:0] moff = offset_of(region, madr);
	wire [ZONE_IW-1:0] zone_idx = moff[ZONE_IW-1:0];
	wire [PW_IW-1:0] pw_idx = moff[PW_IW-1:0];
	wire [CNT_IW-1:0] cnt_idx = moff[CNT_IW-1:0];
	wire [TEST_IW-1:0] test_idx = moff[TEST_IW-1:0];

	wire level_one = issuer_fuse_i;
	wire write_permit = zone_bits[0];
	wire read_permit = zone_bits[1];
	wire count_active = ~level_one & fuse_q;
	wire allow;

	rsac_access_check u_check (
		.op_i(op),
		.region_i(region),
		.level_one_i(level_one),
		.verified_i(verified_q),
		.erase_ok_i(erase_ok_q),
		.write_permit_i(write_permit),
		.read_permit_i(read_permit),
		.count_active_i(count_active),
		.tick_pending_i(tick_q),
		.allow_o(allow)
	);

	wire go_ok = cmd_go & allow;
	wire do_write = go_ok & (op == `RSAC_OP_WRITE);
	wire do_erase = go_ok & (op == `RSAC_OP_ERASE);
	wire do_read = go_ok & (op == `RSAC_OP_READ);
	wire do_pwchk = go_ok & (op == `RSAC_OP_PWCHECK);

	// Zone erase removes everything, including both permission bits
	wire zone_wr = do_write & (region == `RSAC_RG_ZONE);
	wire zone_er = do_erase & (region == `RSAC_RG_ZONE);
	wire pw_wr = do_write & (region == `RSAC_RG_PW);
	wire pw_er = do_erase & (region == `RSAC_RG_PW);
	wire cnt_wr = do_write & (region == `RSAC_RG_CNT);
	wire test_wr = do_write & (region == `RSAC_RG_TEST);
	wire test_er = do_erase & (region == `RSAC_RG_TEST);
	wire fuse_wr = do_write & (region == `RSAC_RG_FUSE);
	wire fuse_er = do_erase & (region == `RSAC_RG_FUSE);

	rsac_bit_store #(
		.WIDTH(ZONE_BITS),
		.IW(ZONE_IW)
	) u_zone (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_en_i(zone_wr),
		.clr_idx_i(zone_idx),
		.erase_i(zone_er),
		.bits_q(zone_bits)
	);

	rsac_bit_store #(
		.WIDTH(PW_BITS),
		.IW(PW_IW)
	) u_pw (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_en_i(pw_wr),
		.clr_idx_i(pw_idx),
		.erase_i(pw_er),
		.bits_q(pw_bits)
	);

	// The counter store is never handed an erase
	rsac_bit_store #(
		.WIDTH(CNT_BITS),
		.IW(CNT_IW)
	) u_cnt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_en_i(cnt_wr),
		.clr_idx_i(cnt_idx),
		.erase_i(1'b0),
		.bits_q(cnt_bits)
	);

	rsac_bit_store #(
		.WIDTH(TEST_BITS),
		.IW(TEST_IW)
	) u_test (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_en_i(test_wr),
		.clr_idx_i(test_idx),
		.erase_i(test_er),
		.bits_q(test_bits)
	);

	// Bit addressed by the current read command
	reg sel_bit;
	always @*
	begin
		sel_bit = 1'b0;
		case (region)
			`RSAC_RG_ZONE: sel_bit = zone_bits[zone_idx];
			`RSAC_RG_PW: sel_bit = pw_bits[pw_idx];
			`RSAC_RG_CNT: sel_bit = cnt_bits[cnt_idx];
			`RSAC_RG_FUSE: sel_bit = fuse_q;
			`RSAC_RG_TEST: sel_bit = test_bits[test_idx];
			default: sel_bit = 1'b0;
		endcase
	end

	// A counter write only earns an erase when it turns a one into a zero
	wire cnt_tick = cnt_wr & count_active & cnt_bits[cnt_idx];
	wire tick_use = zone_er & ~level_one;
	wire logout = wr_req & (wb_adr_i == `RSAC_REG_CTRL) & wb_sel_i[0] &
		wb_dat_i[`RSAC_CTRL_LOGOUT];
	wire pw_match = do_pwchk & (pwcmp_q == pw_bits);
	wire pw_miss = do_pwchk & (pwcmp_q != pw_bits);

	reg verified_d;
	reg erase_ok_d;
	reg tick_d;
	reg fuse_d;

	// Next flag values; a set beats a clear in the same cycle
	always @*
	begin
		verified_d = code_verify_i | (verified_q & ~logout);
		erase_ok_d = pw_match | (erase_ok_q & ~logout & ~pw_miss);
		tick_d = cnt_tick | (tick_q & ~tick_use);
		fuse_d = fuse_er ? 1'b1 : (fuse_wr ? 1'b0 : fuse_q);
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			verified_q <= `RSAC_RST_FLAG;
			erase_ok_q <= `RSAC_RST_FLAG;
			tick_q <= `RSAC_RST_FLAG;
			fuse_q <= `RSAC_RST_FUSE;
		end
		else
		begin
			verified_q <= verified_d;
			erase_ok_q <= erase_ok_d;
			tick_q <= tick_d;
			fuse_q <= fuse_d;
		end
	end

	// Result of the last command
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rdbit_q <= 1'b0;
			refused_q <= 1'b0;
		end
		else if (cmd_go)
		begin
			rdbit_q <= do_read ? sel_bit : 1'b0;
			refused_q <= ~allow;
		end
	end

	// Compare value for the erase password, byte lanes honoured
	integer b;
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pwcmp_q <= `RSAC_RST_DATA;
		end
		else if (wr_req && wb_adr_i == `RSAC_REG_PWCMP)
		begin
			for (b = 0; b < 4; b = b + 1)
			begin
				if (wb_sel_i[b])
				begin
					pwcmp_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
				end
			end
		end
	end

	reg [31:0] rd_mux;
	always @*
	begin
		rd_mux = `RSAC_RST_DATA;
		case (wb_adr_i)
			`RSAC_REG_STATUS:
			begin
				rd_mux[`RSAC_ST_RDBIT] = rdbit_q;
				rd_mux[`RSAC_ST_REFUSED] = refused_q;
				rd_mux[`RSAC_ST_VERIFIED] = verified_q;
				rd_mux[`RSAC_ST_ERASE_OK] = erase_ok_q;
				rd_mux[`RSAC_ST_LEVEL_ONE] = level_one;
				rd_mux[`RSAC_ST_COUNT_ACT] = count_active;
				rd_mux[`RSAC_ST_TICK] = tick_q;
				rd_mux[`RSAC_ST_CNT_FUSE] = fuse_q;
			end
			default: rd_mux = `RSAC_RST_DATA;
		endcase
	end

	// One wait-free answer per request; unmapped offsets ack with zero data
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= `RSAC_RST_DATA;
		end
		else
		begin
			ack_q <= req;
			if (rd_req)
			begin
				dat_q <= rd_mux;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign code_verified_flag_o = verified_q;
	assign zone_two_erase_ok_flag_o = erase_ok_q;
	assign level_one_o = level_one;
endmodule

// file: core/rsac_zone_two_map.vh
// Address map, register layout, operation codes and reset values for the zone-two guard
`ifndef RSAC_ZONE_TWO_MAP_VH
`define RSAC_ZONE_TWO_MAP_VH

// Bus register offsets (byte addresses)
`define RSAC_REG_CMD 8'h00
`define RSAC_REG_PWCMP 8'h04
`define RSAC_REG_STATUS 8'h08
`define RSAC_REG_CTRL 8'h0C

// Command register fields
`define RSAC_CMD_OP_LSB 0
`define RSAC_CMD_OP_MSB 1
`define RSAC_CMD_ADR_LSB 16
`define RSAC_CMD_ADR_MSB 26

// Operation codes
`define RSAC_OP_READ 2'h0
`define RSAC_OP_WRITE 2'h1
`define RSAC_OP_ERASE 2'h2
`define RSAC_OP_PWCHECK 2'h3

// Status register bit positions
`define RSAC_ST_RDBIT 0
`define RSAC_ST_REFUSED 1
`define RSAC_ST_VERIFIED 2
`define RSAC_ST_ERASE_OK 3
`define RSAC_ST_LEVEL_ONE 4
`define RSAC_ST_COUNT_ACT 5
`define RSAC_ST_TICK 6
`define RSAC_ST_CNT_FUSE 7

// Control register bit positions
`define RSAC_CTRL_LOGOUT 0

// Memory bit addresses of the guarded regions
`define RSAC_ADR_ZONE_BASE 11'h1E0
`define RSAC_ADR_WRITE_PERMIT 11'h1E0
`define RSAC_ADR_READ_PERMIT 11'h1E1
`define RSAC_ADR_PW_BASE 11'h2E0
`define RSAC_ADR_CNT_BASE 11'h300
`define RSAC_ADR_FUSE_BASE 11'h3C0
`define RSAC_ADR_FUSE_LAST 11'h3C3
`define RSAC_ADR_TEST_BASE 11'h3E0

// Region codes
`define RSAC_RG_NONE 3'h0
`define RSAC_RG_ZONE 3'h1
`define RSAC_RG_PW 3'h2
`define RSAC_RG_CNT 3'h3
`define RSAC_RG_FUSE 3'h4
`define RSAC_RG_TEST 3'h5

// Reset values
`define RSAC_RST_FLAG 1'b0
`define RSAC_RST_FUSE 1'b1
`define RSAC_RST_DATA 32'h0000_0000

`endif

// file: core/rsac_bit_store.v
// Bit-addressed storage: single bits written to zero, whole field erased to ones
`timescale 1ns/1ps
module rsac_bit_store #(
	parameter WIDTH = 256,
	parameter IW = 8
) (
	input wire clk_i,
	input wire rst_i,
	input wire clr_en_i,
	input wire [IW-1:0] clr_idx_i,
	input wire erase_i,
	output reg [WIDTH-1:0] bits_q
);
	integer k;

	// Erased state is all ones; reset returns the field to that state
	always @(posedge clk_i)
	begin
		if (rst_i || erase_i)
		begin
			bits_q <= {WIDTH{1'b1}};
		end
		else if (clr_en_i)
		begin
			for (k = 0; k < WIDTH; k = k + 1)
			begin
				if (clr_idx_i == k[IW-1:0])
				begin
					bits_q[k] <= 1'b0;
				end
			end
		end
	end
endmodule

// file: core/rsac_access_check.v
// Access decision for one memory operation in the zone-two area
`timescale 1ns/1ps
`include "rsac_zone_two_map.vh"
module rsac_access_check (
	input wire [1:0] op_i,
	input wire [2:0] region_i,
	input wire level_one_i,
	input wire verified_i,
	input wire erase_ok_i,
	input wire write_permit_i,
	input wire read_permit_i,
	input wire count_active_i,
	input wire tick_pending_i,
	output reg allow_o
);
	always @*
	begin
		allow_o = 1'b0;
		case (region_i)
			`RSAC_RG_ZONE:
			begin
				case (op_i)
					`RSAC_OP_READ: allow_o = read_permit_i | verified_i;
					`RSAC_OP_WRITE:
					begin
						if (level_one_i)
							allow_o = verified_i;
						else
							allow_o = verified_i & write_permit_i;
					end
					`RSAC_OP_ERASE:
					begin
						if (level_one_i)
							allow_o = verified_i;
						else
							allow_o = verified_i & erase_ok_i &
								(~count_active_i | tick_pending_i);
					end
					default: allow_o = 1'b0;
				endcase
			end
			`RSAC_RG_PW:
			begin
				case (op_i)
					`RSAC_OP_PWCHECK: allow_o = 1'b1;
					`RSAC_OP_READ: allow_o = level_one_i & verified_i;
					default: allow_o = level_one_i & verified_i;
				endcase
			end
			`RSAC_RG_CNT:
			begin
				case (op_i)
					`RSAC_OP_READ: allow_o = 1'b1;
					`RSAC_OP_WRITE: allow_o = verified_i;
					default: allow_o = 1'b0;
				endcase
			end
			`RSAC_RG_FUSE:
			begin
				case (op_i)
					`RSAC_OP_READ: allow_o = 1'b1;
					`RSAC_OP_WRITE: allow_o = level_one_i & verified_i;
					`RSAC_OP_ERASE: allow_o = level_one_i & verified_i;
					default: allow_o = 1'b0;
				endcase
			end
			`RSAC_RG_TEST: allow_o = (op_i != `RSAC_OP_PWCHECK);
			default: allow_o = 1'b0;
		endcase
	end
endmodule

// file: test/rsac_guard_properties.sv
// Port-level checks on the zone-two guard
`timescale 1ns/1ps
module rsac_guard_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic issuer_fuse_i,
	input wire logic code_verify_i,
	input wire logic code_verified_flag_o,
	input wire logic zone_two_erase_ok_flag_o,
	input wire logic level_one_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_logout;
		s_take ##0 (wb_we_i && wb_adr_i == 8'h0C && wb_sel_i[0] && wb_dat_i[0] && !code_verify_i);
	endsequence
	wire pwcheck_take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00 &&
		wb_sel_i == 4'hF && wb_dat_i[1:0] == 2'h3;
	chk_ack_latency: assert property (s_take |=> wb_ack_o)
		else $error("ack late");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	chk_level_copy: assert property (level_one_o == issuer_fuse_i)
		else $error("level output wrong");
	chk_verify_sets: assert property (code_verify_i |=> code_verified_flag_o)
		else $error("verified flag not set");
	chk_verify_cause: assert property ($rose(code_verified_flag_o) |-> $past(code_verify_i))
		else $error("verified flag set alone");
	chk_logout_clears: assert property (s_logout |=> !code_verified_flag_o)
		else $error("logout failed");
	chk_eok_cause: assert property ($rose(zone_two_erase_ok_flag_o) |-> $past(pwcheck_take))
		else $error("erase flag set alone");
	chk_logout_eok: assert property (s_logout |=> !zone_two_erase_ok_flag_o)
		else $error("logout left erase flag");
	chk_reset_clear: assert property (disable iff (1'b0)
		rst_i |=> !wb_ack_o && !code_verified_flag_o && !zone_two_erase_ok_flag_o)
		else $error("reset state wrong");
endmodule

// file: test/rsac_host_model.sv
// Wishbone host standing in for the card reader
`timescale 1ns/1ps
module rsac_host_model (
	input wire logic clk_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_i,
	output logic [7:0] adr_o,
	output logic [31:0] dat_o,
	output logic [3:0] sel_o,
	output logic we_o,
	output logic cyc_o,
	output logic stb_o,
	output logic to_o
);
	initial
	begin
		adr_o = 8'h00;
		dat_o = 32'h0000_0000;
		sel_o = 4'h0;
		we_o = 1'b0;
		cyc_o = 1'b0;
		stb_o = 1'b0;
		to_o = 1'b0;
	end
	task automatic xfer(input logic [7:0] a, input logic w, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		adr_o <= a;
		we_o <= w;
		dat_o <= d;
		sel_o <= s;
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_i !== 1'b1 && n < 50);
		q = dat_i;
		to_o <= (ack_i !== 1'b1);
		// Released data lines must not look like the last value
		dat_o <= ~d;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
	endtask
endmodule

// file: test/test_rsac_zone_two_guard.sv
// Self-checking bench for the zone-two guard
`timescale 1ns/1ps
module test_rsac_zone_two_guard;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic issuer_fuse_i = 1'b1;
	logic code_verify_i = 1'b0;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [3:0] wb_sel_i;
	logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, to, sv, eok, l1;
	int mismatches = 0, n_compared = 0;
	always #4 clk_i = ~clk_i;
	rsac_zone_two_guard dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.issuer_fuse_i(issuer_fuse_i), .code_verify_i(code_verify_i),
		.code_verified_flag_o(sv), .zone_two_erase_ok_flag_o(eok), .level_one_o(l1));
	rsac_host_model host (.clk_i(clk_i), .dat_i(wb_dat_o), .ack_i(wb_ack_o), .adr_o(wb_adr_i),
		.dat_o(wb_dat_i), .sel_o(wb_sel_i), .we_o(wb_we_i), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i),
		.to_o(to));
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge to)
	begin
		mismatches++;
		final_report();
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		host.xfer(a, 1'b1, 4'hF, d, x);
	endtask
	// Memory command, then the status byte compared with e
	task automatic cmd(input logic [1:0] c, input logic [10:0] a, input logic [7:0] e);
		wr(8'h00, {5'h00, a, 14'h0000, c});
		host.xfer(8'h08, 1'b0, 4'hF, 32'h0000_0000, q);
		chk({24'h00_0000, q[7:0]}, {24'h00_0000, e});
	endtask
	task automatic do_reset(input logic f);
		rst_i <= 1'b1;
		issuer_fuse_i <= f;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic verify();
		@(posedge clk_i);
		code_verify_i <= 1'b1;
		@(posedge clk_i);
		code_verify_i <= 1'b0;
	endtask
	task automatic level_two();
		@(posedge clk_i);
		issuer_fuse_i <= 1'b0;
	endtask
	task automatic t_reset();
		do_reset(1'b1);
		host.xfer(8'h08, 1'b0, 4'hF, 32'h0000_0000, q);
		chk(q, 32'h0000_0090);
		host.xfer(8'h10, 1'b0, 4'hF, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		chk({31'h0000_0000, sv}, 32'h0000_0000);
		chk({31'h0000_0000, eok}, 32'h0000_0000);
		chk({31'h0000_0000, l1}, 32'h0000_0001);
		$display("test reset done");
	endtask
	task automatic t_level_one();
		cmd(2'h1, 11'd482, 8'h92);
		cmd(2'h0, 11'd482, 8'h91);
		cmd(2'h1, 11'd992, 8'h90);
		cmd(2'h0, 11'd992, 8'h90);
		cmd(2'h2, 11'd992, 8'h90);
		cmd(2'h0, 11'd992, 8'h91);
		verify();
		cmd(2'h1, 11'd481, 8'h94);
		cmd(2'h1, 11'd485, 8'h94);
		cmd(2'h0, 11'd485, 8'h94);
		wr(8'h0C, 32'h0000_0001);
		cmd(2'h0, 11'd485, 8'h92);
		verify();
		cmd(2'h1, 11'd480, 8'h94);
		cmd(2'h2, 11'd700, 8'h94);
		cmd(2'h0, 11'd485, 8'h95);
		cmd(2'h1, 11'd480, 8'h94);
		cmd(2'h1, 11'd736, 8'h94);
		cmd(2'h0, 11'd736, 8'h94);
		$display("test level one done");
	endtask
	task automatic t_level_two();
		level_two();
		cmd(2'h1, 11'd737, 8'hA6);
		cmd(2'h0, 11'd736, 8'hA6);
		cmd(2'h1, 11'd960, 8'hA6);
		cmd(2'h1, 11'd486, 8'hA6);
		cmd(2'h2, 11'd490, 8'hA6);
		wr(8'h04, 32'h0000_0000);
		cmd(2'h3, 11'd736, 8'hA4);
		wr(8'h04, 32'hFFFF_FFFE);
		cmd(2'h3, 11'd736, 8'hAC);
		chk({31'h0000_0000, eok}, 32'h0000_0001);
		chk({31'h0000_0000, l1}, 32'h0000_0000);
		cmd(2'h2, 11'd490, 8'hAE);
		cmd(2'h2, 11'd768, 8'hAE);
		cmd(2'h1, 11'd768, 8'hEC);
		cmd(2'h2, 11'd490, 8'hAC);
		cmd(2'h0, 11'd480, 8'hAD);
		for (int i = 1; i < 128; i++)
		begin
			cmd(2'h1, 11'(768 + i), 8'hEC);
			cmd(2'h2, 11'd490, 8'hAC);
		end
		cmd(2'h1, 11'd768, 8'hAC);
		cmd(2'h2, 11'd490, 8'hAE);
		wr(8'h0C, 32'h0000_0001);
		chk({31'h0000_0000, eok}, 32'h0000_0000);
		cmd(2'h0, 11'd480, 8'hA1);
		$display("test level two done");
	endtask
	task automatic t_no_count();
		do_reset(1'b1);
		verify();
		cmd(2'h1, 11'd960, 8'h14);
		cmd(2'h2, 11'd961, 8'h94);
		cmd(2'h1, 11'd963, 8'h14);
		level_two();
		wr(8'h04, 32'hFFFF_FFFF);
		cmd(2'h3, 11'd736, 8'h0C);
		cmd(2'h2, 11'd490, 8'h0C);
		cmd(2'h2, 11'd490, 8'h0C);
		// Only byte lane 0 is written, so the compare value stays all ones
		host.xfer(8'h04, 1'b1, 4'h1, 32'h0000_00FF, q);
		cmd(2'h3, 11'd736, 8'h0C);
		wr(8'h04, 32'h0000_0000);
		cmd(2'h3, 11'd736, 8'h04);
		cmd(2'h2, 11'd490, 8'h06);
		$display("test no count done");
	endtask
	initial
	begin
		t_reset();
		t_level_one();
		t_level_two();
		t_no_count();
		final_report();
	end
endmodule
bind rsac_zone_two_guard rsac_guard_properties chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.issuer_fuse_i(issuer_fuse_i), .code_verify_i(code_verify_i),
	.code_verified_flag_o(code_verified_flag_o),
	.zone_two_erase_ok_flag_o(zone_two_erase_ok_flag_o), .level_one_o(level_one_o));
